//--- inc/mdc_pkg.sv
// Shared constants and types for the cascaded parallel configuration loader
package mdc_pkg;

    // Clock and configuration clock timing
    localparam int CLK_PERIOD_PS       = 4000;
    localparam int CFG_CLK_MAX_PER_NS  = 50;
    localparam int CFG_CLK_HALF_CYC    = (CFG_CLK_MAX_PER_NS * 1000 / 2) / CLK_PERIOD_PS;
    localparam int CFG_CLK_CNT_W       = 4;

    // Data bus layout
    localparam int FLASH_ADDR_W        = 24;
    localparam int FLASH_DATA_W        = 16;
    localparam int LANE_W              = 8;
    localparam int LANE_LO_LSB         = 0;
    localparam int LANE_HI_LSB         = 8;
    localparam int BYTES_PER_WORD      = 2;

    // Flash start point, in 16-bit word addressing
    localparam logic [23:0] BOOT_WORD_ADDR = 24'h010000;

    // Scheme strap encodings
    localparam logic [1:0] SCHEME_AP   = 2'h1;
    localparam logic [1:0] SCHEME_FPP  = 2'h2;

    // Default sizes and counts
    localparam int OWN_BYTES_DEF       = 1024;
    localparam int BYTE_CNT_W          = 24;
    localparam int INIT_CYCLES_DEF     = 16;
    localparam int INIT_CNT_W          = 16;

    // Device state
    typedef enum logic [2:0] {
        MDC_ST_RESET  = 3'b000,
        MDC_ST_WAIT   = 3'b001,
        MDC_ST_LOAD   = 3'b010,
        MDC_ST_DONE   = 3'b011,
        MDC_ST_INIT   = 3'b100,
        MDC_ST_USER   = 3'b101
    } mdc_state_type;

endpackage

//--- design/mdc_chain_device.sv
// Configuration chain device: active parallel master or fast passive parallel slave
`timescale 1ns/1ps
module mdc_chain_device
    import mdc_pkg::*;
#(
    parameter int OWN_BYTES   = OWN_BYTES_DEF,
    parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    // Straps
    input  wire logic [1:0]               scheme_select_pins,
    input  wire logic                     lane_select_high,
    // Chain control
    input  wire logic                     reconfigure_request_n,
    input  wire logic                     chain_enable_n_in,
    output logic                          chain_enable_n_out,
    // Open-drain completion line
    input  wire logic                     load_complete_line_in,
    output logic                          load_complete_line_out,
    output logic                          load_complete_line_oe,
    // Open-drain status line
    input  wire logic                     config_status_line_n_in,
    output logic                          config_status_line_n_out,
    output logic                          config_status_line_n_oe,
    // Configuration clock
    input  wire logic                     config_clock_in,
    output logic                          config_clock_out,
    output logic                          config_clock_oe,
    // Flash bus
    output logic [FLASH_ADDR_W-1:0]       flash_address_bus,
    output logic                          flash_ce_n,
    output logic                          flash_output_enable_n,
    output logic                          flash_address_valid_n,
    output logic                          flash_write_enable_n,
    output logic                          flash_reset_n,
    output logic                          flash_bus_oe,
    input  wire logic [FLASH_DATA_W-1:0]  flash_data_in,
    input  wire logic                     flash_wait,
    // Toward the configuration memory of this device
    output logic [FLASH_DATA_W-1:0]       cfg_data,
    output logic                          cfg_data_valid,
    output logic                          cfg_data_word,
    // User side
    output logic                          init_active,
    output logic                          user_mode,
    output logic                          user_flash_wait
);

    localparam logic [BYTE_CNT_W-1:0]    OWN_BYTES_L   = BYTE_CNT_W'(OWN_BYTES);
    localparam logic [BYTE_CNT_W-1:0]    WORD_BYTES_L  = BYTE_CNT_W'(BYTES_PER_WORD);
    localparam logic [CFG_CLK_CNT_W-1:0] HALF_LAST     = CFG_CLK_CNT_W'(CFG_CLK_HALF_CYC - 1);
    localparam logic [INIT_CNT_W-1:0]    INIT_LAST     = INIT_CNT_W'(INIT_CYCLES - 1);

    mdc_state_type                 state_q;
    logic [1:0]                    scheme_q;
    logic                          lane_hi_q;
    logic                          is_master;
    logic                          is_slave;
    logic                          reconfig_active;
    logic                          own_loaded;
    logic [CFG_CLK_CNT_W-1:0]      div_cnt_q;
    logic                          cclk_q;
    logic                          cclk_rise;
    logic                          cclk_in_q;
    logic                          slave_edge;
    logic                          slave_take;
    logic                          master_take;
    logic [BYTE_CNT_W-1:0]         byte_cnt_q;
    logic [INIT_CNT_W-1:0]         init_cnt_q;
    logic                          bus_owned;

    assign reconfig_active = ~reconfigure_request_n;
    assign is_master       = (scheme_q == SCHEME_AP);
    assign is_slave        = (scheme_q == SCHEME_FPP);
    assign own_loaded      = (byte_cnt_q >= OWN_BYTES_L);
    // The bus is ours only while enabled from outside; another master parks us by pulling it high
    assign bus_owned       = is_master & ~chain_enable_n_in
                             & ((state_q == MDC_ST_LOAD) | (state_q == MDC_ST_DONE));

    // Straps are caught while the device is held in reset, never by the async reset itself
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scheme_q  <= 2'h0;
            lane_hi_q <= 1'b0;
        end else if (state_q == MDC_ST_RESET) begin
            scheme_q  <= scheme_select_pins;
            lane_hi_q <= lane_select_high;
        end
    end

    // Main sequence
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= MDC_ST_RESET;
        end else if (reconfig_active) begin
            state_q <= MDC_ST_RESET;
        end else begin
            unique case (state_q)
                MDC_ST_RESET: begin
                    state_q <= MDC_ST_WAIT;
                end
                MDC_ST_WAIT: begin
                    // Every device must have released status before anyone starts
                    if (config_status_line_n_in && (is_master || is_slave)) begin
                        state_q <= MDC_ST_LOAD;
                    end
                end
                MDC_ST_LOAD: begin
                    if (own_loaded) begin
                        state_q <= MDC_ST_DONE;
                    end
                end
                MDC_ST_DONE: begin
                    if (load_complete_line_in) begin
                        state_q <= MDC_ST_INIT;
                    end
                end
                MDC_ST_INIT: begin
                    if (init_cnt_q == INIT_LAST) begin
                        state_q <= MDC_ST_USER;
                    end
                end
                MDC_ST_USER: begin
                    state_q <= MDC_ST_USER;
                end
                default: begin
                    state_q <= MDC_ST_RESET;
                end
            endcase
        end
    end

    // Initialization counter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            init_cnt_q <= '0;
        end else if (state_q == MDC_ST_INIT) begin
            init_cnt_q <= init_cnt_q + INIT_CNT_W'(1);
        end else begin
            init_cnt_q <= '0;
        end
    end

    // Configuration clock divider; half period rounded down keeps it at or above 20 MHz
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q <= '0;
            cclk_q    <= 1'b0;
        end else if (!bus_owned) begin
            div_cnt_q <= '0;
            cclk_q    <= 1'b0;
        end else if (div_cnt_q == HALF_LAST) begin
            div_cnt_q <= '0;
            cclk_q    <= ~cclk_q;
        end else begin
            div_cnt_q <= div_cnt_q + CFG_CLK_CNT_W'(1);
        end
    end

    assign cclk_rise = bus_owned & (div_cnt_q == HALF_LAST) & ~cclk_q;

    // Slave sees the master clock as a synchronous input
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cclk_in_q <= 1'b0;
        end else begin
            cclk_in_q <= config_clock_in;
        end
    end

    assign slave_edge  = config_clock_in & ~cclk_in_q;
    assign slave_take  = is_slave & (state_q == MDC_ST_LOAD) & slave_edge
                         & ~chain_enable_n_in & ~own_loaded;
    // Master keeps clocking words after its own share so the slave chains still load
    assign master_take = cclk_rise & (state_q == MDC_ST_LOAD) & ~own_loaded;

    // Byte count of this device's own share
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            byte_cnt_q <= '0;
        end else if (state_q == MDC_ST_RESET) begin
            byte_cnt_q <= '0;
        end else if (master_take) begin
            byte_cnt_q <= byte_cnt_q + WORD_BYTES_L;
        end else if (slave_take) begin
            byte_cnt_q <= byte_cnt_q + BYTE_CNT_W'(1);
        end
    end

    // Captured data toward the configuration memory
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_data       <= '0;
            cfg_data_valid <= 1'b0;
            cfg_data_word  <= 1'b0;
        end else begin
            cfg_data_valid <= master_take | slave_take;
            if (master_take) begin
                cfg_data      <= flash_data_in;
                cfg_data_word <= 1'b1;
            end else if (slave_take) begin
                cfg_data_word <= 1'b0;
                if (lane_hi_q) begin
                    cfg_data <= {8'h00, flash_data_in[LANE_HI_LSB +: LANE_W]};
                end else begin
                    cfg_data <= {8'h00, flash_data_in[LANE_LO_LSB +: LANE_W]};
                end
            end
        end
    end

    // Chain enable out; the master's single output feeds both slave chains at once
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chain_enable_n_out <= 1'b1;
        end else if (reconfig_active || state_q == MDC_ST_RESET || state_q == MDC_ST_WAIT) begin
            chain_enable_n_out <= 1'b1;
        end else if (own_loaded) begin
            chain_enable_n_out <= 1'b0;
        end
    end

    // Open-drain completion and status lines: only pull low or release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            load_complete_line_out   <= 1'b0;
            load_complete_line_oe    <= 1'b1;
            config_status_line_n_out <= 1'b0;
            config_status_line_n_oe  <= 1'b1;
        end else begin
            load_complete_line_out   <= 1'b0;
            config_status_line_n_out <= 1'b0;
            config_status_line_n_oe  <= reconfig_active | (state_q == MDC_ST_RESET);
            if (reconfig_active || state_q == MDC_ST_RESET) begin
                load_complete_line_oe <= 1'b1;
            end else if (own_loaded) begin
                load_complete_line_oe <= 1'b0;
            end
        end
    end

    // Flash bus drive; all of it floats while reconfigure is low or another master owns it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flash_bus_oe          <= 1'b0;
            flash_address_bus     <= BOOT_WORD_ADDR;
            flash_ce_n            <= 1'b1;
            flash_output_enable_n <= 1'b1;
            flash_address_valid_n <= 1'b1;
            flash_write_enable_n  <= 1'b1;
            flash_reset_n         <= 1'b0;
            config_clock_out      <= 1'b0;
            config_clock_oe       <= 1'b0;
        end else if (reconfig_active || !bus_owned) begin
            flash_bus_oe          <= 1'b0;
            flash_address_bus     <= BOOT_WORD_ADDR;
            flash_ce_n            <= 1'b1;
            flash_output_enable_n <= 1'b1;
            flash_address_valid_n <= 1'b1;
            flash_write_enable_n  <= 1'b1;
            flash_reset_n         <= 1'b0;
            config_clock_out      <= 1'b0;
            config_clock_oe       <= 1'b0;
        end else begin
            flash_bus_oe          <= 1'b1;
            flash_ce_n            <= 1'b0;
            flash_output_enable_n <= 1'b0;
            flash_write_enable_n  <= 1'b1;
            flash_reset_n         <= 1'b1;
            config_clock_out      <= cclk_q;
            config_clock_oe       <= 1'b1;
            // Address valid only ahead of the first word; reads then stream
            flash_address_valid_n <= ~flash_ce_n;
            if (cclk_rise) begin
                flash_address_bus <= flash_address_bus + FLASH_ADDR_W'(1);
            end
        end
    end

    // Wait from the flash never stalls configuration; user logic sees it afterwards
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            user_flash_wait <= 1'b0;
            init_active     <= 1'b0;
            user_mode       <= 1'b0;
        end else begin
            user_flash_wait <= (state_q == MDC_ST_USER) & flash_wait;
            init_active     <= (state_q == MDC_ST_INIT);
            user_mode       <= (state_q == MDC_ST_USER);
        end
    end

endmodule

//--- verification/mdc_chain_device_properties.sv
// Checker for the chain device ports, bound to every instance
`timescale 1ns/1ps
module mdc_chain_device_checker
    import mdc_pkg::*;
(
    // Clock, reset and inputs
    input wire logic                    clk_sys,
    input wire logic                    arst_n,
    input wire logic                    reconfigure_request_n,
    input wire logic                    chain_enable_n_in,
    input wire logic                    lane_select_high,
    input wire logic                    load_complete_line_in,
    input wire logic [FLASH_DATA_W-1:0] flash_data_in,
    // Chain and open-drain outputs
    input wire logic                    chain_enable_n_out,
    input wire logic                    load_complete_line_out,
    input wire logic                    load_complete_line_oe,
    input wire logic                    config_status_line_n_out,
    // Flash side
    input wire logic                    config_clock_out,
    input wire logic                    config_clock_oe,
    input wire logic [FLASH_ADDR_W-1:0] flash_address_bus,
    input wire logic                    flash_bus_oe,
    // Captured data and user side
    input wire logic [FLASH_DATA_W-1:0] cfg_data,
    input wire logic                    cfg_data_valid,
    input wire logic                    cfg_data_word,
    input wire logic                    init_active,
    input wire logic                    user_mode,
    input wire logic                    user_flash_wait
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_LANE_BYTE: assert property (
        cfg_data_valid && !cfg_data_word |-> cfg_data == {8'h00,
        lane_select_high ? $past(flash_data_in[15:8]) : $past(flash_data_in[7:0])})
        else $error("slave byte not from its lane");
    AST_DONE_WITH_ENABLE: assert property (chain_enable_n_out == load_complete_line_oe)
        else $error("completion release apart from chain enable");
    // A reconfigure out of init leaves init showing for one more cycle
    AST_HOLD_UNTIL_LOADED: assert property (
        load_complete_line_oe && $past(reconfigure_request_n) |-> !init_active && !user_mode)
        else $error("init while own data missing");
    AST_INIT_ON_LINE: assert property ($rose(init_active) |-> $past(load_complete_line_in, 2))
        else $error("init without completion line high");
    AST_OPEN_DRAIN: assert property (
        load_complete_line_out == 1'b0 && config_status_line_n_out == 1'b0)
        else $error("open-drain line driven high");
    AST_RECONF_FLOAT: assert property (
        !reconfigure_request_n |-> ##2 !flash_bus_oe && !config_clock_oe)
        else $error("flash bus driven during reconfigure");
    AST_ENABLE_OWNS_BUS: assert property (chain_enable_n_in |=> !flash_bus_oe)
        else $error("flash bus driven while disabled");
    AST_WAIT_IGNORED: assert property (
        (init_active || cfg_data_valid) |-> !user_flash_wait)
        else $error("flash wait passed during configuration");
    AST_CLOCK_WITH_BUS: assert property (config_clock_oe |-> flash_bus_oe)
        else $error("configuration clock without flash bus");
    // A reconfigure or the end of loading may cut a phase short
    AST_CLOCK_HIGH_PHASE: assert property (
        @(posedge clk_sys) disable iff (!arst_n || !reconfigure_request_n || load_complete_line_in)
        $rose(config_clock_out) |=> config_clock_out[*5] ##1 !config_clock_out)
        else $error("configuration clock high phase wrong");
    // The clock pin lags the capture by one stage; rises after the own share carry no word
    AST_WORD_PER_CLOCK: assert property (
        $rose(config_clock_out) && $past(chain_enable_n_out) |-> $past(cfg_data_valid) && $past(cfg_data_word)
        && flash_address_bus == $past(flash_address_bus, 2) + 24'h000001)
        else $error("word transfer not tied to clock rise");
    AST_MASTER_WORD: assert property (
        cfg_data_valid && cfg_data_word |-> cfg_data == $past(flash_data_in))
        else $error("master word differs from flash data");
    AST_SLAVE_ENABLED: assert property (
        cfg_data_valid && !cfg_data_word |-> $past(!chain_enable_n_in) && $past(load_complete_line_oe))
        else $error("slave captured while not enabled");

    cover property ($rose(config_clock_out));
    cover property (cfg_data_valid && !cfg_data_word);
    cover property ($rose(user_mode));
endmodule

bind mdc_chain_device mdc_chain_device_checker i_mdc_chain_device_checker (.clk_sys, .arst_n,
    .reconfigure_request_n, .chain_enable_n_in, .lane_select_high, .load_complete_line_in,
    .flash_data_in, .chain_enable_n_out, .load_complete_line_out, .load_complete_line_oe,
    .config_status_line_n_out, .config_clock_out, .config_clock_oe, .flash_address_bus,
    .flash_bus_oe, .cfg_data, .cfg_data_valid, .cfg_data_word, .init_active, .user_mode,
    .user_flash_wait);

//--- verification/mdc_flash_model.sv
// Behavioural parallel flash answering word reads
`timescale 1ns/1ps
module mdc_flash_model
    import mdc_pkg::*;
(
    // Clock
    input  wire logic                    clk_sys,
    // Flash bus from the loader
    input  wire logic [FLASH_ADDR_W-1:0] flash_address_bus,
    input  wire logic                    flash_ce_n,
    input  wire logic                    flash_output_enable_n,
    input  wire logic                    flash_bus_oe,
    // Data toward the loader
    output logic [FLASH_DATA_W-1:0]      flash_dq
);
    logic [FLASH_DATA_W-1:0] dq_q = 16'h0000;
    // Undriven bus toggles each cycle so a stale word never passes as valid
    always @(posedge clk_sys) begin
        if (flash_bus_oe && !flash_ce_n && !flash_output_enable_n) begin
            dq_q <= {~flash_address_bus[7:0], flash_address_bus[7:0]};
        end else begin
            dq_q <= ~dq_q;
        end
    end
    assign flash_dq = dq_q;
endmodule

//--- verification/mdc_chain_device_tb.sv
// Self-checking bench for the chain device as master and as slave
`timescale 1ns/1ps
module mdc_chain_device_tb;
    import mdc_pkg::*;
    localparam int OWN_B  = 8;
    localparam int INIT_C = 4;
    // Stimulus
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [1:0]  scheme = SCHEME_AP;
    logic        lane = 1'b0;
    logic        reconf_n = 1'b1;
    logic        ce_in_n = 1'b0;
    logic        peer_hold = 1'b1;
    logic        clk_in = 1'b0;
    logic        fwait = 1'b0;
    logic [15:0] tb_data = 16'h0000;
    // Observed
    logic        ce_out_n, done_oe, stat_oe, bus_oe, ce_n, oe_n, valid, word, init_act, user, uwait;
    logic        avd_n, we_n, frst_n;
    logic [23:0] addr;
    logic [15:0] cfg, dq, data_in;
    wire         done_line = !(done_oe || peer_hold);
    int          errors = 0;
    int          n_checks = 0;
    assign data_in = (scheme == SCHEME_FPP) ? tb_data : dq;
    always #2 clk_sys = ~clk_sys;

    mdc_chain_device #(.OWN_BYTES(OWN_B), .INIT_CYCLES(INIT_C)) i_mdc_chain_device (
        .clk_sys, .arst_n, .scheme_select_pins(scheme), .lane_select_high(lane),
        .reconfigure_request_n(reconf_n), .chain_enable_n_in(ce_in_n), .chain_enable_n_out(ce_out_n),
        .load_complete_line_in(done_line), .load_complete_line_out(), .load_complete_line_oe(done_oe),
        .config_status_line_n_in(!stat_oe), .config_status_line_n_out(), .config_status_line_n_oe(stat_oe),
        .config_clock_in(clk_in), .config_clock_out(), .config_clock_oe(),
        .flash_address_bus(addr), .flash_ce_n(ce_n), .flash_output_enable_n(oe_n), .flash_address_valid_n(avd_n),
        .flash_write_enable_n(we_n), .flash_reset_n(frst_n), .flash_bus_oe(bus_oe), .flash_data_in(data_in),
        .flash_wait(fwait), .cfg_data(cfg), .cfg_data_valid(valid), .cfg_data_word(word),
        .init_active(init_act), .user_mode(user), .user_flash_wait(uwait));
    mdc_flash_model i_mdc_flash_model (.clk_sys, .flash_address_bus(addr), .flash_ce_n(ce_n),
        .flash_output_enable_n(oe_n), .flash_bus_oe(bus_oe), .flash_dq(dq));

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic restart(input logic [1:0] s, input logic l);
        arst_n = 1'b0;
        scheme = s;
        lane = l;
        ce_in_n = 1'b0;
        reconf_n = 1'b1;
        peer_hold = 1'b1;
        clk_in = 1'b0;
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic wait_valid(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (valid !== 1'b1 && n < 60);
        check("word valid", valid, 1'b1);
    endtask

    // Rise held three cycles, then two low, to keep the rise spacing legal
    task automatic slave_pulse(output logic got);
        got = 1'b0;
        clk_in = 1'b1;
        repeat (3) begin
            @(negedge clk_sys);
            got = got | valid;
        end
        clk_in = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic test_master_load();
        int n;
        restart(SCHEME_AP, 1'b0);
        fwait = 1'b1;
        for (int k = 0; k < OWN_B / 2; k++) begin
            wait_valid(n);
            check("master word", cfg, {8'h00, ~k[7:0], k[7:0]});
            check("word flag", word, 1'b1);
            check("flash address", addr, BOOT_WORD_ADDR + 24'(k + 1));
            if (k > 0) begin
                check("word spacing", 24'(n), 24'h00000C);
            end
        end
        check("flash reset released", frst_n, 1'b1);
        check("flash write idle", we_n, 1'b1);
        check("address valid after first word", avd_n, 1'b1);
        repeat (3) @(negedge clk_sys);
        check("chain enable out", ce_out_n, 1'b0);
        check("completion pull", done_oe, 1'b0);
        repeat (20) @(negedge clk_sys);
        check("init while held", init_act, 1'b0);
        peer_hold = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("init entry", init_act, 1'b1);
        check("wait during init", uwait, 1'b0);
        repeat (INIT_C + 4) @(negedge clk_sys);
        check("user mode", user, 1'b1);
        check("wait in user", uwait, 1'b1);
    endtask

    task automatic test_bus_handoff();
        int n;
        restart(SCHEME_AP, 1'b0);
        wait_valid(n);
        reconf_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("bus float on reconfigure", bus_oe, 1'b0);
        check("flash reset on reconfigure", frst_n, 1'b0);
        check("chip enable on reconfigure", ce_n, 1'b1);
        ce_in_n = 1'b1;
        repeat (123) @(negedge clk_sys);
        reconf_n = 1'b1;
        repeat (20) @(negedge clk_sys);
        check("bus held off", bus_oe, 1'b0);
        ce_in_n = 1'b0;
        @(negedge clk_sys);
        reconf_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        reconf_n = 1'b1;
        wait_valid(n);
        check("restart word", cfg, 24'h00FF00);
        check("restart address", addr, BOOT_WORD_ADDR + 24'h000001);
    endtask

    task automatic test_slave_lane(input logic l);
        logic       got;
        logic [7:0] b;
        restart(SCHEME_FPP, l);
        ce_in_n = 1'b1;
        tb_data = 16'h5AA5;
        slave_pulse(got);
        check("capture while disabled", got, 1'b0);
        ce_in_n = 1'b0;
        for (int k = 0; k < OWN_B; k++) begin
            b = 8'h30 + 8'(k);
            tb_data = l ? {b, ~b} : {~b, b};
            slave_pulse(got);
            check("slave capture", got, 1'b1);
            check("slave byte", cfg, {8'h00, b});
        end
        check("slave chain enable out", ce_out_n, 1'b0);
        check("slave completion pull", done_oe, 1'b0);
        slave_pulse(got);
        check("capture after share", got, 1'b0);
    endtask

    // An unknown scheme strap must never start a load
    task automatic test_idle_scheme();
        restart(2'h0, 1'b0);
        repeat (30) @(negedge clk_sys);
        check("idle scheme bus", bus_oe, 1'b0);
        check("idle scheme chain enable", ce_out_n, 1'b1);
        check("idle scheme completion pull", done_oe, 1'b1);
    endtask

    initial begin
        test_master_load();
        test_bus_handoff();
        test_slave_lane(1'b0);
        test_slave_lane(1'b1);
        test_idle_scheme();
        complete_run();
    end

    // All scenarios need about 500 cycles; this allows a hundred times that
    initial begin
        #200000;
        errors++;
        complete_run();
    end
endmodule
